// ### design/cpl_link.sv
`timescale 1ns/1ps
`include "cpl_cfg.svh"

// Small synchronous FIFO, registered input ready
module cpl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Occupancy and flags
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid  = (count != '0);
  assign out_data   = mem[rd_ptr];

  // Pointers, storage and registered ready
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count    <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule

module cpl_link
  import cpl_pkg::*;
#(
  parameter int unsigned BIT_CYC    = `CPL_BIT_CYC,
  parameter int unsigned ACK_CYC    = `CPL_ACK_CYC,
  parameter int unsigned FIFO_DEPTH = `CPL_FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             rx_line,
  output logic                  tx_line,
  input  wire logic             tx_in_valid,
  input  wire cpl_pkg::cpl_byte_t tx_in_data,
  output logic                  tx_in_ready,
  output logic                  rx_out_valid,
  output cpl_pkg::cpl_byte_t    rx_out_data,
  output logic                  rx_out_first,
  output logic                  rx_out_last,
  output logic                  frame_err,
  output logic                  ack_timeout
);
  import cpl_pkg::*;

  localparam logic [8:0] HALF_BIT = 9'(BIT_CYC / 2);
  localparam logic [8:0] FULL_BIT = 9'(BIT_CYC - 1);
  localparam logic [31:0] ACK_LAST = 32'(ACK_CYC - 1);

  // One reflected CRC step over a byte
  function automatic logic [15:0] crc_step(input logic [15:0] c, input cpl_byte_t b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CPL_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Serial receiver, mid-bit sampling
  logic [8:0] rxd_cnt;
  logic [3:0] rxd_bit;
  logic       rxd_busy;
  cpl_byte_t  rxd_sh;
  logic       rxd_done;
  cpl_byte_t  rxd_byte;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxd_cnt  <= 9'h000;
      rxd_bit  <= 4'h0;
      rxd_busy <= 1'b0;
      rxd_sh   <= 8'h00;
      rxd_done <= 1'b0;
      rxd_byte <= 8'h00;
    end else begin
      rxd_done <= 1'b0;
      if (!rxd_busy) begin
        if (!rx_line) begin
          rxd_busy <= 1'b1;
          rxd_cnt  <= HALF_BIT;
          rxd_bit  <= 4'h0;
        end
      end else if (rxd_cnt != 9'h000) begin
        rxd_cnt <= rxd_cnt - 9'h001;
      end else begin
        rxd_cnt <= FULL_BIT;
        if (rxd_bit == 4'h0 && rx_line) begin
          rxd_busy <= 1'b0;                         // False start
        end else if (rxd_bit < 4'h9) begin
          if (rxd_bit != 4'h0) rxd_sh <= {rx_line, rxd_sh[7:1]};
          rxd_bit <= rxd_bit + 4'h1;
        end else begin
          rxd_busy <= 1'b0;
          rxd_done <= rx_line;                      // Stop bit must be high
          rxd_byte <= rxd_sh;
        end
      end
    end
  end

  // Receive framer
  cpl_rx_state_t rs;
  cpl_byte_t     r_type;
  cpl_byte_t     r_len;
  cpl_byte_t     r_idx;
  cpl_byte_t     r_crc_lo;
  logic [15:0]   r_crc;
  cpl_byte_t     r_buf [22];
  wire           len_bad  = (rxd_byte > `CPL_MAX_LEN);
  wire           crc_bad  = ({rxd_byte, r_crc_lo} != ~r_crc);
  wire           emit_end = (r_idx == r_len + 8'h01);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rs           <= RF_TYPE;
      r_type       <= 8'h00;
      r_len        <= 8'h00;
      r_idx        <= 8'h00;
      r_crc_lo     <= 8'h00;
      r_crc        <= `CPL_CRC_INIT;
      frame_err    <= 1'b0;
      rx_out_valid <= 1'b0;
      rx_out_data  <= 8'h00;
      rx_out_first <= 1'b0;
      rx_out_last  <= 1'b0;
    end else begin
      frame_err    <= 1'b0;
      rx_out_valid <= 1'b0;
      rx_out_first <= 1'b0;
      rx_out_last  <= 1'b0;
      unique case (rs)
        RF_TYPE: if (rxd_done) begin
          r_type <= rxd_byte;
          r_crc  <= crc_step(`CPL_CRC_INIT, rxd_byte);
          rs     <= RF_LEN;
        end
        RF_LEN: if (rxd_done) begin
          if (len_bad) begin
            frame_err <= 1'b1;
            rs        <= RF_TYPE;                          // Hunt from next byte
          end else begin
            r_len <= rxd_byte;
            r_idx <= 8'h00;
            r_crc <= crc_step(r_crc, rxd_byte);
            rs    <= (rxd_byte == 8'h00) ? RF_CRCL : RF_DATA;
          end
        end
        RF_DATA: if (rxd_done) begin
          r_buf[r_idx[4:0]] <= rxd_byte;
          r_crc <= crc_step(r_crc, rxd_byte);
          r_idx <= r_idx + 8'h01;
          if (r_idx == r_len - 8'h01) rs <= RF_CRCL;
        end
        RF_CRCL: if (rxd_done) begin
          r_crc_lo <= rxd_byte;
          rs       <= RF_CRCH;
        end
        RF_CRCH: if (rxd_done) begin
          r_idx <= 8'h00;
          if (crc_bad) begin
            frame_err <= 1'b1;
            rs        <= RF_TYPE;
          end else begin
            rs <= RF_EMIT;
          end
        end
        RF_EMIT: begin
          rx_out_valid <= 1'b1;
          rx_out_first <= (r_idx == 8'h00);
          rx_out_last  <= emit_end;
          rx_out_data  <= (r_idx == 8'h00) ? r_type :
                          (r_idx == 8'h01) ? r_len  : r_buf[5'(r_idx - 8'h02)];
          r_idx        <= r_idx + 8'h01;
          if (emit_end) rs <= RF_TYPE;
        end
      endcase
    end
  end

  a_bad_len_err: assert property (
    rxd_done && rs == RF_LEN && len_bad |=> frame_err && rs == RF_TYPE)
    else $error("oversize length not flagged");
  a_bad_crc_drop: assert property (
    rxd_done && rs == RF_CRCH && crc_bad |=> frame_err ##1 !rx_out_valid)
    else $error("bad check value not dropped");
  a_len_bound: assert property (
    rx_out_first |=> rx_out_valid && rx_out_data <= `CPL_MAX_LEN)
    else $error("delivered length above limit");
  a_resync_hunt: assert property (
    frame_err |-> rs == RF_TYPE)
    else $error("receiver did not return to hunting");

  // Transmit buffer
  logic      f_valid;
  cpl_byte_t f_data;
  logic      f_ready;

  cpl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (tx_in_valid),
    .in_data   (tx_in_data),
    .in_ready  (tx_in_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_ready)
  );

  // Acknowledge tracking and transmit framer state
  logic          ack_pend;
  logic [31:0]   ack_cnt;
  logic [5:0]    last_code;
  cpl_tx_state_t ts;
  logic          t_auto;
  cpl_byte_t     t_len;
  cpl_byte_t     t_idx;
  logic [15:0]   t_crc;
  logic          utx_busy;
  logic [8:0]    utx_sh;
  logic [8:0]    utx_cnt;
  logic [3:0]    utx_bits;

  // Byte selection for the transmit framer
  wire       auto_fire  = (ts == TF_IDLE) && ack_pend && (ack_cnt >= ACK_LAST);
  wire       need_fifo  = (ts == TF_IDLE && !auto_fire) || (ts == TF_LEN && !t_auto) ||
                          (ts == TF_DATA);
  wire       t_have     = need_fifo ? f_valid : 1'b1;
  wire       t_fire     = !utx_busy && t_have && (ts != TF_IDLE || auto_fire || f_valid);
  wire       is_reply   = f_data[`CPL_RESP_BIT];
  wire [7:0] head_byte  = auto_fire ? {`CPL_ERR_TYPE, last_code} :
                          is_reply  ? {f_data[7:6], last_code} : f_data;
  wire [7:0] t_byte     = (ts == TF_IDLE) ? head_byte :
                          (ts == TF_LEN && t_auto) ? 8'h00 :
                          (ts == TF_CRCL) ? ~t_crc[7:0] :
                          (ts == TF_CRCH) ? ~t_crc[15:8] : f_data;
  wire       reply_go   = t_fire && (ts == TF_IDLE) && (auto_fire || is_reply);
  assign f_ready = t_fire && need_fifo;

  // Command acknowledge deadline, a new command wins over a clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_pend    <= 1'b0;
      ack_cnt     <= 32'h0000_0000;
      last_code   <= 6'h00;
      ack_timeout <= 1'b0;
    end else begin
      ack_timeout <= t_fire && auto_fire;
      ack_cnt     <= ack_pend ? ack_cnt + 32'h0000_0001 : 32'h0000_0000;
      if (reply_go) ack_pend <= 1'b0;
      if (rs == RF_EMIT && emit_end) begin
        ack_pend  <= 1'b1;
        ack_cnt   <= 32'h0000_0000;
        last_code <= r_type[5:0];
      end
    end
  end

  // Transmit framer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ts     <= TF_IDLE;
      t_auto <= 1'b0;
      t_len  <= 8'h00;
      t_idx  <= 8'h00;
      t_crc  <= `CPL_CRC_INIT;
    end else if (t_fire) begin
      unique case (ts)
        TF_IDLE: begin
          t_auto <= auto_fire;
          t_crc  <= crc_step(`CPL_CRC_INIT, t_byte);
          ts     <= TF_LEN;
        end
        TF_LEN: begin
          t_len <= t_byte;
          t_idx <= 8'h00;
          t_crc <= crc_step(t_crc, t_byte);
          ts    <= (t_byte == 8'h00) ? TF_CRCL : TF_DATA;
        end
        TF_DATA: begin
          t_crc <= crc_step(t_crc, t_byte);
          t_idx <= t_idx + 8'h01;
          if (t_idx == t_len - 8'h01) ts <= TF_CRCL;
        end
        TF_CRCL: ts <= TF_CRCH;
        TF_CRCH: ts <= TF_IDLE;
      endcase
    end
  end

  // Serial transmitter, start, eight data, stop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_line  <= 1'b1;
      utx_busy <= 1'b0;
      utx_sh   <= 9'h1FF;
      utx_cnt  <= 9'h000;
      utx_bits <= 4'h0;
    end else if (t_fire) begin
      tx_line  <= 1'b0;                                // Start bit
      utx_busy <= 1'b1;
      utx_sh   <= {1'b1, t_byte};
      utx_cnt  <= FULL_BIT;
      utx_bits <= 4'h9;
    end else if (utx_busy) begin
      if (utx_cnt != 9'h000) begin
        utx_cnt <= utx_cnt - 9'h001;
      end else if (utx_bits != 4'h0) begin
        tx_line  <= utx_sh[0];
        utx_sh   <= {1'b1, utx_sh[8:1]};
        utx_bits <= utx_bits - 4'h1;
        utx_cnt  <= FULL_BIT;
      end else begin
        utx_busy <= 1'b0;
      end
    end
  end

  a_tx_idle_high: assert property (
    !utx_busy |-> tx_line)
    else $error("line not idle high");
  a_tx_start_bit: assert property (
    t_fire |=> !tx_line && utx_busy)
    else $error("start bit missing");
  a_crc_lsb_first: assert property (
    t_fire && ts == TF_CRCL |=> ts == TF_CRCH && utx_sh[7:0] == ~t_crc[7:0])
    else $error("check low byte not sent first");
  a_zero_len_crc: assert property (
    t_fire && ts == TF_LEN && t_byte == 8'h00 |=> ts == TF_CRCL)
    else $error("empty packet did not go to check value");
  a_reply_code: assert property (
    reply_go |=> utx_sh[5:0] == $past(last_code) && utx_sh[6])
    else $error("reply type lost command code");
  a_ack_deadline: assert property (
    auto_fire && !utx_busy && !(rs == RF_EMIT && emit_end) |=> !ack_pend && ack_timeout)
    else $error("overdue acknowledge not sent");

endmodule

// ### design/cpl_cfg.svh
`ifndef CPL_CFG_SVH
`define CPL_CFG_SVH

// Line rate and system clock
`define CPL_CLK_HZ 40000000
`define CPL_BAUD 115200
`define CPL_BIT_CYC (`CPL_CLK_HZ / `CPL_BAUD)

// Packet layout
`define CPL_MAX_LEN 8'h16
`define CPL_RESP_BIT 6
`define CPL_ERR_TYPE 2'h3

// Check value
`define CPL_CRC_POLY 16'h8408
`define CPL_CRC_INIT 16'hFFFF

// Acknowledge deadline
`define CPL_ACK_MS 250
`define CPL_ACK_CYC (`CPL_ACK_MS * (`CPL_CLK_HZ / 1000))

// Transmit buffer
`define CPL_FIFO_DEPTH 4

`endif

// ### design/cpl_pkg.sv
package cpl_pkg;

  // Receive framer states
  typedef enum logic [5:0] {
    RF_TYPE = 6'h01,
    RF_LEN  = 6'h02,
    RF_DATA = 6'h04,
    RF_CRCL = 6'h08,
    RF_CRCH = 6'h10,
    RF_EMIT = 6'h20
  } cpl_rx_state_t;

  // Transmit framer states
  typedef enum logic [4:0] {
    TF_IDLE = 5'h01,
    TF_LEN  = 5'h02,
    TF_DATA = 5'h04,
    TF_CRCL = 5'h08,
    TF_CRCH = 5'h10
  } cpl_tx_state_t;

  typedef logic [7:0] cpl_byte_t;

endpackage

// ### dv/cpl_host.sv
`timescale 1ns/1ps

// Host side of the link: sends framed commands, collects reply characters
module cpl_host
  import cpl_pkg::*;
#(
  parameter int unsigned BIT_CYC = 16
) (
  input  wire logic core_clk,
  input  wire logic from_dut,
  output logic      to_dut
);
  cpl_byte_t got_q[$];
  int        stop_bad = 0;

  // Idle line is high
  initial to_dut = 1'b1;

  // Reflected check, all-ones start, inverted result
  function automatic logic [15:0] crc_of(input cpl_byte_t q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    return ~c;
  endfunction

  // One character: start low, LSB first, stop high
  task automatic send_byte(input cpl_byte_t b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      #1 to_dut = f[i];
      repeat (BIT_CYC - 1) @(posedge core_clk);
    end
    #1;  // Return off the clock edge
  endtask

  // Whole packet, check low byte first right after payload, optionally spoilt
  task automatic send_pkt(input cpl_byte_t q[$], input bit bad);
    logic [15:0] c;
    c = crc_of(q) ^ {15'h0000, bad};
    foreach (q[i]) send_byte(q[i]);
    send_byte(c[7:0]);
    send_byte(c[15:8]);
  endtask

  // Mid-bit sampling of each character from the block
  always begin
    cpl_byte_t b;
    @(negedge from_dut);
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge core_clk);
      b[i] = from_dut;
    end
    repeat (BIT_CYC) @(posedge core_clk);
    if (from_dut !== 1'b1) stop_bad++;
    got_q.push_back(b);
  end
endmodule

// ### dv/cpl_link_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module cpl_link_bench;
  import cpl_pkg::*;
  localparam int unsigned BC = 16;
  localparam int unsigned AC = 2000;

  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       rx_line;
  logic       tx_line;
  logic       tx_in_valid = 1'b0;
  cpl_byte_t  tx_in_data = 8'h00;
  logic       tx_in_ready;
  logic       rx_out_valid;
  cpl_byte_t  rx_out_data;
  logic       rx_out_first;
  logic       rx_out_last;
  logic       frame_err;
  logic       ack_timeout;
  int         failures = 0;
  int         check_count = 0;
  int         ferr_n = 0;
  int         ack_n = 0;
  logic [9:0] rx_q[$];
  bit         saw_stall;

  always #12.5 core_clk = ~core_clk;

  cpl_link #(.BIT_CYC(BC), .ACK_CYC(AC), .FIFO_DEPTH(4)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .rx_line(rx_line), .tx_line(tx_line),
    .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data), .tx_in_ready(tx_in_ready),
    .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data), .rx_out_first(rx_out_first),
    .rx_out_last(rx_out_last), .frame_err(frame_err), .ack_timeout(ack_timeout)
  );

  cpl_host #(.BIT_CYC(BC)) host (.core_clk(core_clk), .from_dut(tx_line), .to_dut(rx_line));

  // Collect delivered beats and count pulses
  always @(posedge core_clk) begin
    if (rx_out_valid === 1'b1) rx_q.push_back({rx_out_first, rx_out_last, rx_out_data});
    if (frame_err === 1'b1) ferr_n++;
    if (ack_timeout === 1'b1) ack_n++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Delivered stream must match, first and last flags included
  task automatic expect_rx(input cpl_byte_t q[$]);
    int n;
    logic [9:0] g;
    n = 0;
    while (rx_q.size() < q.size() && n < 8000) begin
      cyc(1);
      n++;
    end
    foreach (q[i]) begin
      g = (rx_q.size() > 0) ? rx_q.pop_front() : 10'h3FF;
      `CHK("rx_beat", {i == 0, i == q.size() - 1, q[i]}, g)  // Beat order
    end
  endtask

  // Outgoing packet plus appended check, low byte first
  task automatic expect_tx(input cpl_byte_t q[$]);
    int n;
    logic [15:0] c;
    cpl_byte_t g;
    c = host.crc_of(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    n = 0;
    while (host.got_q.size() < q.size() && n < 8000) begin
      cyc(1);
      n++;
    end
    foreach (q[i]) begin
      g = (host.got_q.size() > 0) ? host.got_q.pop_front() : ~q[i];
      `CHK("tx_byte", q[i], g)  // Wire bytes
    end
  endtask

  // Offer bytes back to back, noting any refusal
  task automatic push_pkt(input cpl_byte_t q[$]);
    int n;
    foreach (q[i]) begin
      tx_in_valid = 1'b1;
      tx_in_data = q[i];
      n = 0;
      @(negedge core_clk);
      while (tx_in_ready !== 1'b1 && n < 4000) begin
        saw_stall = 1'b1;
        @(negedge core_clk);
        n++;
      end
      @(posedge core_clk);
      #1;
    end
    tx_in_valid = 1'b0;
  endtask

  // Short response acknowledging a command
  task automatic reply(input cpl_byte_t cmd);
    push_pkt('{8'h40, 8'h00});
    expect_tx('{8'h40 | (cmd & 8'h3F), 8'h00});  // Low six bits kept
  endtask

  task automatic t_auto_ack;
    int a;
    int f;
    a = ack_n;
    f = ferr_n;
    host.send_pkt('{8'h05, 8'h03, 8'h11, 8'h22, 8'h33}, 1'b0);
    expect_rx('{8'h05, 8'h03, 8'h11, 8'h22, 8'h33});
    expect_tx('{8'hC5, 8'h00});  // Error ack by block
    `CHK("ack_pulse", a + 1, ack_n)  // One pulse
    `CHK("ferr_none", f, ferr_n)  // Good packet
    $display("TEST auto_ack done");
  endtask

  task automatic t_reply_fill;
    int a;
    host.send_pkt('{8'h0A, 8'h00}, 1'b0);
    expect_rx('{8'h0A, 8'h00});  // Empty payload
    a = ack_n;
    saw_stall = 1'b0;
    push_pkt('{8'h80, 8'h01, 8'h03, 8'h40, 8'h03, 8'hAA, 8'h55, 8'h0F});
    `CHK("fifo_stall", 1'b1, saw_stall)  // Back-pressure seen
    expect_tx('{8'h80, 8'h01, 8'h03});  // Report sent as is
    expect_tx('{8'h4A, 8'h03, 8'hAA, 8'h55, 8'h0F});  // Reply type
    cyc(AC + 500);
    `CHK("no_auto_ack", a, ack_n)  // Reply clears deadline
    `CHK("tx_quiet", 0, host.got_q.size())  // No stray packet
    $display("TEST reply_fill done");
  endtask

  task automatic t_bad_len;
    int f;
    f = ferr_n;
    host.send_byte(8'h07);
    host.send_byte(8'h17);
    cyc(4);
    `CHK("ferr_len", f + 1, ferr_n)  // Oversize length
    host.send_pkt('{8'h12, 8'h01, 8'h99}, 1'b0);
    expect_rx('{8'h12, 8'h01, 8'h99});  // Relock
    reply(8'h12);  // Host waits for ack
    $display("TEST bad_len done");
  endtask

  task automatic t_bad_crc;
    cpl_byte_t q[$];
    int f;
    f = ferr_n;
    host.send_pkt('{8'h03, 8'h02, 8'h01, 8'h02}, 1'b1);
    cyc(4);
    `CHK("ferr_crc", f + 1, ferr_n)  // Check mismatch
    `CHK("rx_none", 0, rx_q.size())  // Dropped
    q = '{8'h21, 8'h16};
    for (int i = 0; i < 22; i++) q.push_back(8'(i));
    host.send_pkt(q, 1'b0);
    expect_rx(q);  // Longest payload
    reply(8'h21);
    `CHK("stop_bits", 0, host.stop_bad)  // Framing
    $display("TEST bad_crc done");
  endtask

  task automatic tally_and_finish;
    $display("TOTAL checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Reset, then each scenario in turn
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("rst_tx_line", 1'b1, tx_line)  // Line idles high
    `CHK("rst_ready", 1'b0, tx_in_ready)  // Nothing taken in reset
    rst_n = 1'b1;
    cyc(10);
    t_auto_ack;
    t_reply_fill;
    t_bad_len;
    t_bad_crc;
    tally_and_finish;
  end

  // Hang guard, well beyond the expected run
  initial begin
    #(25 * 60000);
    failures++;
    $display("BAD watchdog exp done got timeout");
    tally_and_finish;
  end
endmodule
